// *** shared/follower_pkg.sv ***
// constants, register map and carrier types for the setpoint follower
package follower_pkg;
  // time base: one millisecond expressed in core clock cycles
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] ADDR_MODE      = 8'h00;
  localparam logic [7:0] ADDR_CTRL      = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_IP_TARGET = 8'h0c;
  localparam logic [7:0] ADDR_BUF_EN    = 8'h10;
  localparam logic [7:0] ADDR_PERIOD    = 8'h14;
  localparam logic [7:0] ADDR_TIME_IDX  = 8'h18;
  localparam logic [7:0] ADDR_PROF_VEL  = 8'h1c;
  localparam logic [7:0] ADDR_MAX_PROF  = 8'h20;
  localparam logic [7:0] ADDR_MAX_MOTOR = 8'h24;
  localparam logic [7:0] ADDR_FE_WIN    = 8'h28;
  localparam logic [7:0] ADDR_FE_TIME   = 8'h2c;
  localparam logic [7:0] ADDR_LIM_MIN   = 8'h30;
  localparam logic [7:0] ADDR_LIM_MAX   = 8'h34;
  localparam logic [7:0] ADDR_CS_TARGET = 8'h38;
  localparam logic [7:0] ADDR_DEMAND    = 8'h3c;

  // operating mode selector values
  localparam logic [7:0] MODE_IP  = 8'h07;
  localparam logic [7:0] MODE_CSP = 8'h08;

  // control and status bit positions
  localparam int CW_IP_ENABLE = 4;
  localparam int CW_HALT      = 8;
  localparam int SW_SYNC      = 8;
  localparam int SW_REACHED   = 10;
  localparam int SW_LIMIT     = 11;
  localparam int SW_ACTIVE    = 12;
  localparam int SW_FOLLOW    = 13;

  // only the millisecond time base is supported
  localparam logic [7:0] TIME_IDX_MS = 8'hfd;

  // reset values
  localparam logic [15:0] RST_PERIOD  = 16'h0001;
  localparam logic [31:0] RST_VEL     = 32'h0000_03e8;
  localparam logic [31:0] RST_FE_WIN  = 32'h0000_0100;
  localparam logic [15:0] RST_FE_TIME = 16'h000a;
  localparam logic [31:0] RST_LIM_MIN = 32'h8000_0000;
  localparam logic [31:0] RST_LIM_MAX = 32'h7fff_ffff;

  // register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_ip   = 3'b010,
    st_csp  = 3'b100
  } run_state_e;
endpackage

// *** hdl/setpoint_follower.sv ***
// position setpoint follower: interpolated and cyclic synchronous modes
`timescale 1ns/1ns
`default_nettype none

// How it works
// (R1) mode selector 7 selects interpolated position mode
// (R2) mode selector 8 selects cyclic synchronous position mode
// (R3) controller sends sync pulses regularly, preferably at a fixed interval
// (R4) sync tracking starts only once network state is operational
// (R5) interpolation runs only while control bit 4 is one
// (R6) halt rising stops the motor; halt falling resumes toward target
// (R7) status bit 10: target reached, or zero speed when halted
// (R8) status bit 12 is one while interpolation is active
// (R9) straight-line path to one buffered target only
// (R10) interpolation target accepted only while buffer enable is one
// (R11) speed capped by profile velocity and smaller of two maxima
// (R12) interpolation period in milliseconds spaces successive targets
// (R13) controller delivers each next target before the interval expires
// (R14) motor energised and moved only in operation enabled state
// (R15) cyclic mode follows the absolute preset with no ramp
// (R16) cyclic mode ignores control word bits, bit 4 included
// (R17) repeated identical cyclic target gives identical behaviour
// (R18) status bit 8 shows sync with the fieldbus cycle in cyclic mode
// (R19) status bit 12 shows the cyclic target drives position control
// (R20) status bit 13 flags error outside window past timeout
// (R21) status bit 11 flags demand beyond the software limits
// (R22) cycle time is period times ten to index; only minus three
module setpoint_follower #(
  parameter int unsigned MS_CYCLES = follower_pkg::CYCLES_PER_MS
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   clk_en,
  input  wire follower_pkg::bus_req_s bus_req,
  output logic [31:0]                 rd_data,
  input  wire logic                   nmt_operational,
  input  wire logic                   sync_pulse,
  input  wire logic                   op_enabled,
  input  wire logic [31:0]            actual_pos,
  output logic [31:0]                 demand_pos,
  output logic                        motor_enable,
  output logic [15:0]                 status_word,
  output logic                        interpolation_running_flag
);
  import follower_pkg::*;

  // magnitude of a signed difference
  function automatic logic [31:0] mag(input logic [31:0] a, input logic [31:0] b);
    logic signed [32:0] d;
    d = $signed({a[31], a}) - $signed({b[31], b});
    mag = d[32] ? 32'(-d) : d[31:0];
  endfunction

  // smaller of two unsigned values
  function automatic logic [31:0] min_u(input logic [31:0] a, input logic [31:0] b);
    min_u = (a < b) ? a : b;
  endfunction

  // software-written registers
  logic [7:0]  mode_q;
  logic [15:0] ctrl_q;
  logic [31:0] ip_pend_q;
  logic        buf_en_q;
  logic [15:0] period_q;
  logic [7:0]  time_idx_q;
  logic [31:0] prof_vel_q;
  logic [31:0] max_prof_q;
  logic [31:0] max_motor_q;
  logic [31:0] fe_win_q;
  logic [15:0] fe_time_q;
  logic [31:0] lim_min_q;
  logic [31:0] lim_max_q;
  logic [31:0] cs_target_q;

  // block state
  run_state_e  state_q;
  run_state_e  state_d;
  logic [31:0] ms_cnt_q;
  logic [15:0] since_sync_q;
  logic        synced_q;
  logic [31:0] demand_q;
  logic [31:0] seg_target_q;
  logic [31:0] step_q;
  logic        halt_prev_q;
  logic        moved_q;
  logic [15:0] fe_cnt_q;
  logic        fe_q;
  logic [15:0] status_q;
  logic        motor_en_q;
  logic        ip_run_q;
  logic [31:0] rd_data_q;

  // decode and selection
  wire        wr_en      = clk_en & bus_req.wr;
  wire        rd_en      = clk_en & bus_req.rd;
  wire        ms_tick    = (ms_cnt_q == 32'(MS_CYCLES - 1));
  wire        base_ok    = (time_idx_q == TIME_IDX_MS);                 // [R22]
  wire        sync_ok    = sync_pulse & nmt_operational & base_ok;      // [R4]
  wire        in_ip      = (state_q == st_ip);
  wire        in_csp     = (state_q == st_csp);
  wire        halt       = ctrl_q[CW_HALT];
  wire        halt_rise  = halt & ~halt_prev_q;                         // [R6]
  wire        ip_active  = in_ip & ctrl_q[CW_IP_ENABLE] & op_enabled
                           & synced_q;                                  // [R5]
  wire        csp_follow = in_csp & op_enabled & synced_q;              // [R16]
  wire        ip_move    = ip_active & ~halt & ~halt_rise;              // [R6]
  wire [31:0] vel_lim    = min_u(prof_vel_q, min_u(max_prof_q, max_motor_q)); // [R11]
  wire [31:0] seg_len    = mag(ip_pend_q, demand_q);
  wire [31:0] seg_step   = seg_len / {16'h0000, (period_q == 16'h0000) ? 16'h0001 : period_q};
  wire [31:0] step_cap   = min_u((seg_step == 32'h0) ? 32'h1 : seg_step, vel_lim);
  wire [31:0] to_go      = mag(seg_target_q, demand_q);
  wire        tgt_above  = $signed(seg_target_q) > $signed(demand_q);
  wire        at_target  = (demand_q == seg_target_q);
  wire        out_window = mag(actual_pos, demand_q) > fe_win_q;        // [R20]
  wire        beyond_lim = ($signed(demand_q) < $signed(lim_min_q))
                           | ($signed(demand_q) > $signed(lim_max_q));  // [R21]
  wire [31:0] sync_limit = {15'h0000, period_q, 1'b0};

  // next step of interpolation, snapping onto the target at the end
  wire [31:0] ip_next    = (to_go <= step_q) ? seg_target_q
                           : tgt_above ? demand_q + step_q
                           : demand_q - step_q;                         // [R9]

  // status word: sync bit only has meaning in cyclic mode
  wire        reached    = halt_prev_q ? ~moved_q : at_target;          // [R7]
  wire [15:0] status_d   = (16'(in_csp & synced_q) << SW_SYNC)          // [R18]
                         | (16'(in_ip & reached) << SW_REACHED)         // [R7]
                         | (16'(beyond_lim) << SW_LIMIT)                // [R21]
                         | (16'(ip_active | csp_follow) << SW_ACTIVE)   // [R8] [R19]
                         | (16'(fe_q) << SW_FOLLOW);                    // [R20]

  // mode selection state machine
  always_comb begin
    case (mode_q)
      MODE_IP:  state_d = st_ip;                                        // [R1]
      MODE_CSP: state_d = st_csp;                                       // [R2]
      default:  state_d = st_idle;
    endcase
  end

  // read data mux, unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    case (bus_req.addr)
      ADDR_MODE:      rd_mux = {24'h0, mode_q};
      ADDR_CTRL:      rd_mux = {16'h0, ctrl_q};
      ADDR_STATUS:    rd_mux = {16'h0, status_q};
      ADDR_IP_TARGET: rd_mux = ip_pend_q;
      ADDR_BUF_EN:    rd_mux = {31'h0, buf_en_q};
      ADDR_PERIOD:    rd_mux = {16'h0, period_q};
      ADDR_TIME_IDX:  rd_mux = {24'h0, time_idx_q};
      ADDR_PROF_VEL:  rd_mux = prof_vel_q;
      ADDR_MAX_PROF:  rd_mux = max_prof_q;
      ADDR_MAX_MOTOR: rd_mux = max_motor_q;
      ADDR_FE_WIN:    rd_mux = fe_win_q;
      ADDR_FE_TIME:   rd_mux = {16'h0, fe_time_q};
      ADDR_LIM_MIN:   rd_mux = lim_min_q;
      ADDR_LIM_MAX:   rd_mux = lim_max_q;
      ADDR_CS_TARGET: rd_mux = cs_target_q;
      ADDR_DEMAND:    rd_mux = demand_q;
      default:        rd_mux = 32'h0;
    endcase
  end

  // register writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_q      <= 8'h00;
      ctrl_q      <= 16'h0000;
      ip_pend_q   <= 32'h0;
      buf_en_q    <= 1'b0;
      period_q    <= RST_PERIOD;
      time_idx_q  <= TIME_IDX_MS;
      prof_vel_q  <= RST_VEL;
      max_prof_q  <= RST_VEL;
      max_motor_q <= RST_VEL;
      fe_win_q    <= RST_FE_WIN;
      fe_time_q   <= RST_FE_TIME;
      lim_min_q   <= RST_LIM_MIN;
      lim_max_q   <= RST_LIM_MAX;
      cs_target_q <= 32'h0;
    end else if (wr_en) begin
      case (bus_req.addr)
        ADDR_MODE:      mode_q      <= bus_req.wdata[7:0];
        ADDR_CTRL:      ctrl_q      <= bus_req.wdata[15:0];
        ADDR_IP_TARGET: if (buf_en_q) ip_pend_q <= bus_req.wdata;       // [R10]
        ADDR_BUF_EN:    buf_en_q    <= bus_req.wdata[0];
        ADDR_PERIOD:    period_q    <= bus_req.wdata[15:0];             // [R12]
        ADDR_TIME_IDX:  time_idx_q  <= bus_req.wdata[7:0];
        ADDR_PROF_VEL:  prof_vel_q  <= bus_req.wdata;
        ADDR_MAX_PROF:  max_prof_q  <= bus_req.wdata;
        ADDR_MAX_MOTOR: max_motor_q <= bus_req.wdata;
        ADDR_FE_WIN:    fe_win_q    <= bus_req.wdata;
        ADDR_FE_TIME:   fe_time_q   <= bus_req.wdata[15:0];
        ADDR_LIM_MIN:   lim_min_q   <= bus_req.wdata;
        ADDR_LIM_MAX:   lim_max_q   <= bus_req.wdata;
        ADDR_CS_TARGET: cs_target_q <= bus_req.wdata;                   // [R17]
        default:        ;
      endcase
    end
  end

  // read port, data valid the cycle after the strobe only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data_q <= 32'h0;
    end else if (clk_en) begin
      rd_data_q <= rd_en ? rd_mux : 32'h0;
    end
  end

  // millisecond base and sync watchdog; two missed periods drop sync
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ms_cnt_q     <= 32'h0;
      since_sync_q <= 16'h0000;
      synced_q     <= 1'b0;
    end else if (clk_en) begin
      ms_cnt_q <= ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
      if (!nmt_operational || !base_ok) begin                           // [R4] [R22]
        synced_q     <= 1'b0;
        since_sync_q <= 16'h0000;
      end else if (sync_ok) begin
        synced_q     <= 1'b1;
        since_sync_q <= 16'h0000;
      end else if (ms_tick) begin
        since_sync_q <= since_sync_q + 16'h0001;
        if ({16'h0, since_sync_q} >= sync_limit) synced_q <= 1'b0;      // [R3]
      end
    end
  end

  // demand generation per mode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q      <= st_idle;
      demand_q     <= 32'h0;
      seg_target_q <= 32'h0;
      step_q       <= 32'h1;
      halt_prev_q  <= 1'b0;
      moved_q      <= 1'b0;
    end else if (clk_en) begin
      state_q     <= state_d;
      halt_prev_q <= halt;
      if (ms_tick) moved_q <= 1'b0;
      if (state_q != state_d) begin
        // a fresh mode starts from rest at the present demand
        seg_target_q <= demand_q;
      end else if (in_ip) begin
        // a new segment opens on each sync, one target deep
        if (sync_ok && ip_active) begin
          seg_target_q <= ip_pend_q;                                    // [R9] [R13]
          step_q       <= step_cap;                                     // [R11] [R12]
        end else if (ms_tick && ip_move && !at_target) begin
          demand_q <= ip_next;                                          // [R5] [R14]
          moved_q  <= 1'b1;
        end
      end else if (in_csp && csp_follow && sync_ok) begin
        // absolute preset taken as is; resending changes nothing
        demand_q     <= cs_target_q;                                    // [R15] [R17]
        seg_target_q <= cs_target_q;
        moved_q      <= (cs_target_q != demand_q);
      end
    end
  end

  // following error: millisecond count while outside the window
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fe_cnt_q <= 16'h0000;
      fe_q     <= 1'b0;
    end else if (clk_en) begin
      if (!out_window || !op_enabled) begin
        fe_cnt_q <= 16'h0000;
        fe_q     <= 1'b0;
      end else if (ms_tick) begin
        if (fe_cnt_q >= fe_time_q) begin
          fe_q <= 1'b1;                                                 // [R20]
        end else begin
          fe_cnt_q <= fe_cnt_q + 16'h0001;
        end
      end
    end
  end

  // registered outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_q   <= 16'h0000;
      motor_en_q <= 1'b0;
      ip_run_q   <= 1'b0;
    end else if (clk_en) begin
      status_q   <= status_d;
      motor_en_q <= op_enabled & ~(state_q == st_idle);                 // [R14]
      ip_run_q   <= ip_active;                                          // [R8]
    end
  end

  assign rd_data                    = rd_data_q;
  assign demand_pos                 = demand_q;
  assign motor_enable               = motor_en_q;
  assign status_word                = status_q;
  assign interpolation_running_flag = ip_run_q;
endmodule // setpoint_follower

`default_nettype wire

// *** dv/follower_sva.sv ***
// port assertions for the setpoint follower
`timescale 1ns/1ns
`default_nettype none
module follower_checker
  import follower_pkg::*;
(
  input wire logic                   core_clk,
  input wire logic                   rst,
  input wire logic                   clk_en,
  input wire follower_pkg::bus_req_s bus_req,
  input wire logic [31:0]            rd_data,
  input wire logic                   nmt_operational,
  input wire logic                   sync_pulse,
  input wire logic                   op_enabled,
  input wire logic [31:0]            demand_pos,
  input wire logic                   motor_enable,
  input wire logic [15:0]            status_word,
  input wire logic                   interpolation_running_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // a read strobe taken at one register
  sequence rd_of(logic [7:0] a);
    clk_en && bus_req.rd && bus_req.addr == a;
  endsequence

  // bus answers
  rd_idle_zero_a: assert property (clk_en && !bus_req.rd |=> rd_data == 32'h0)
    else $error("read data not zero without a read");
  status_read_a: assert property (rd_of(ADDR_STATUS) |=> rd_data == {16'h0, $past(status_word)})
    else $error("status read mismatch");
  demand_read_a: assert property (rd_of(ADDR_DEMAND) |=> rd_data == $past(demand_pos))
    else $error("demand read mismatch");
  // power gating: no drive and no motion outside operation enabled
  motor_off_a: assert property (clk_en && !op_enabled |=> !motor_enable)
    else $error("motor energised while not enabled");
  hold_demand_a: assert property ((clk_en && !op_enabled) [*2] |=> $stable(demand_pos))
    else $error("demand moved while not enabled");
  // sync flag needs an accepted pulse two cycles earlier and drops without network
  sync_cause_a: assert property ($rose(status_word[SW_SYNC]) |-> $past(sync_pulse, 2) && $past(nmt_operational, 2))
    else $error("sync flag rose without a sync pulse");
  sync_drop_a: assert property ((clk_en && !nmt_operational) [*3] |-> !status_word[SW_SYNC])
    else $error("sync flag held without network");
  ip_active_a: assert property (interpolation_running_flag |-> status_word[SW_ACTIVE])
    else $error("active bit clear while interpolating");
endmodule // follower_checker

bind setpoint_follower follower_checker u_chk (.core_clk, .rst, .clk_en, .bus_req, .rd_data,
  .nmt_operational, .sync_pulse, .op_enabled, .demand_pos, .motor_enable, .status_word,
  .interpolation_running_flag);
`default_nettype wire

// *** dv/sync_master.sv ***
// higher-level controller model: sends sync pulses at a fixed interval
`timescale 1ns/1ns
`default_nettype none
module sync_master #(
  parameter int unsigned MS_CYCLES = 20
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic [15:0] period_ms,
  output logic             sync_pulse
);
  int unsigned cnt_q;

  // fixed spacing keeps the drive's period check happy
  always_ff @(posedge core_clk) begin
    if (rst || !run) begin
      cnt_q      <= 0;
      sync_pulse <= 1'b0;
    end else if (cnt_q + 1 >= period_ms * MS_CYCLES) begin
      cnt_q      <= 0;
      sync_pulse <= 1'b1;
    end else begin
      cnt_q      <= cnt_q + 1;
      sync_pulse <= 1'b0;
    end
  end
endmodule // sync_master
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the setpoint follower
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import follower_pkg::*;
  localparam int unsigned MS = 20;
  logic        core_clk, rst, clk_en, nmt_operational, op_enabled, run;
  logic        sync_pulse, motor_enable, interpolation_running_flag;
  bus_req_s    bus_req;
  logic [31:0] rd_data, actual_pos, demand_pos, rv, d1;
  logic [15:0] status_word, period_ms;
  int          err_count, n_tests;

  setpoint_follower #(.MS_CYCLES(MS)) DUT (.core_clk, .rst, .clk_en, .bus_req, .rd_data,
    .nmt_operational, .sync_pulse, .op_enabled, .actual_pos, .demand_pos, .motor_enable,
    .status_word, .interpolation_running_flag);
  sync_master #(.MS_CYCLES(MS)) partner (.core_clk, .rst, .run, .period_ms, .sync_pulse);

  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic chkrd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  task automatic ms(input int n);
    repeat (n * MS) @(posedge core_clk);
    @(negedge core_clk); // outputs settled, away from the launching edge
  endtask

  task automatic summarize();
    $display("tests=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog sized well above the roughly 1100 cycles of the sequence
  initial begin
    repeat (6000) @(posedge core_clk);
    err_count++;
    summarize();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    nmt_operational = 1'b0;
    op_enabled = 1'b0;
    run = 1'b0;
    period_ms = 16'h0001;
    actual_pos = 32'h0;
    bus_req = '0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    chkrd(ADDR_PERIOD, 32'h0000_0001);
    chkrd(ADDR_TIME_IDX, 32'h0000_00fd);
    chkrd(ADDR_PROF_VEL, RST_VEL);
    chkrd(ADDR_FE_WIN, RST_FE_WIN);
    chkrd(ADDR_LIM_MAX, RST_LIM_MAX);
    chkrd(8'h40, 32'h0);
    wr(ADDR_IP_TARGET, 32'h55);
    chkrd(ADDR_IP_TARGET, 32'h0);
    wr(ADDR_BUF_EN, 32'h1);
    wr(ADDR_IP_TARGET, 32'h55);
    chkrd(ADDR_IP_TARGET, 32'h55);
    // cyclic mode with bit 4 clear, then with control bits set
    @(posedge core_clk);
    nmt_operational <= 1'b1;
    op_enabled <= 1'b1;
    run <= 1'b1;
    wr(ADDR_CS_TARGET, 32'h1234);
    wr(ADDR_MODE, {24'h0, MODE_CSP});
    wr(ADDR_CTRL, 32'h0);
    ms(3);
    chk({16'h0, status_word & 16'h3100}, 32'h1100);
    chk(demand_pos, 32'h1234);
    chk({31'h0, motor_enable}, 32'h1);
    chkrd(ADDR_DEMAND, 32'h1234);
    rd(ADDR_STATUS, rv);
    wr(ADDR_CS_TARGET, 32'h1234);
    wr(ADDR_CS_TARGET, 32'h1234);
    wr(ADDR_LIM_MAX, 32'h1000);
    ms(2);
    chk(demand_pos, 32'h1234);
    chk({16'h0, status_word & 16'h0800}, 32'h0800);
    ms(8);
    chk({16'h0, status_word & 16'h2000}, 32'h2000);
    @(posedge core_clk);
    actual_pos <= 32'h1234;
    wr(ADDR_CTRL, 32'h110);
    wr(ADDR_CS_TARGET, 32'h1300);
    wr(ADDR_LIM_MAX, RST_LIM_MAX);
    ms(2);
    chk(demand_pos, 32'h1300);
    chk({16'h0, status_word & 16'h2800}, 32'h0);
    // sync loss through the time index and through the network state
    wr(ADDR_TIME_IDX, 32'h0);
    ms(4);
    chk({16'h0, status_word & 16'h1100}, 32'h0);
    wr(ADDR_TIME_IDX, 32'hfd);
    nmt_operational <= 1'b0;
    ms(3);
    chk({16'h0, status_word & 16'h0100}, 32'h0);
    @(posedge core_clk);
    nmt_operational <= 1'b1;
    ms(3);
    chk({16'h0, status_word & 16'h0100}, 32'h0100);
    // interpolation: 400 units over a 4 ms period, capped at 50 per ms
    @(posedge core_clk);
    period_ms <= 16'h0004;
    wr(ADDR_PERIOD, 32'h4);
    wr(ADDR_PROF_VEL, 32'h32);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_MODE, {24'h0, MODE_IP});
    wr(ADDR_IP_TARGET, 32'h1490);
    ms(5);
    chk({31'h0, interpolation_running_flag}, 32'h0);
    chk(demand_pos, 32'h1300);
    wr(ADDR_CTRL, 32'h10);
    ms(6);
    chk({31'h0, interpolation_running_flag}, 32'h1);
    chk({31'h0, demand_pos !== 32'h1490}, 32'h1);
    wr(ADDR_CTRL, 32'h110);
    ms(1);
    d1 = demand_pos;
    ms(2);
    chk(demand_pos, d1);
    chk({16'h0, status_word & 16'h0400}, 32'h0400);
    wr(ADDR_CTRL, 32'h10);
    ms(12);
    chk(demand_pos, 32'h1490);
    chk({16'h0, status_word & 16'h0400}, 32'h0400);
    // a write while the clock enable is low must not land
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(ADDR_PROF_VEL, 32'h64);
    clk_en <= 1'b1;
    chkrd(ADDR_PROF_VEL, 32'h32);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
